//--- sssc_pkg.sv
// package of constants for the sequence setup block
// What this block does
// - bit0 clear follows run input, set forces on
// - bit2 clear honours forward prohibit input
// - bit3 clear honours reverse prohibit input
// - bit4 picks rotation or current-limit status
// - bit5 set auto-clears momentary stop alarm
// - abnormal stop brakes, or coasts when bit6
// - bit7 keeps brake applied after stop
// - bit6 set, bit8 clear opens brake
// - bit8 set stops over-travel by torque
// - bit9 set holds position, no loop
// - bitA clear clears counter on off-alarm
// - bitb clear enables PI to P switch
// - bits d,C choose switch criterion
// - bitF enables pulse-stop in position mode
// - internal speed rejects pulses, limits off
// - setup changes apply after power cycle
// - word2 bit2 clear gives position mode
// - bitF picks gain reduction or pulse stop
`default_nettype none
package sssc_pkg;
  localparam logic [11:0] SSSC_OFF_SEQ_SETUP = 12'h000;
  localparam logic [11:0] SSSC_OFF_CMD_SETUP = 12'h004;
  localparam logic [11:0] SSSC_OFF_ACTIVE = 12'h008;
  localparam logic [11:0] SSSC_OFF_STATUS = 12'h00C;
  localparam logic [11:0] SSSC_OFF_IRQ_STAT = 12'h010;
  localparam logic [11:0] SSSC_OFF_IRQ_MASK = 12'h014;
  localparam logic [15:0] SSSC_SEQ_RESET = 16'h20EC;
  localparam logic [15:0] SSSC_CMD_RESET = 16'h0408;
  localparam int SSSC_B_RUN_FORCE = 0;
  localparam int SSSC_B_FWD_IGN = 2;
  localparam int SSSC_B_REV_IGN = 3;
  localparam int SSSC_B_STAT_SEL = 4;
  localparam int SSSC_B_AUTO_CLR = 5;
  localparam int SSSC_B_COAST = 6;
  localparam int SSSC_B_BRAKE_HOLD = 7;
  localparam int SSSC_B_OT_TORQUE = 8;
  localparam int SSSC_B_OT_HOLD = 9;
  localparam int SSSC_B_KEEP_DEV = 10;
  localparam int SSSC_B_NO_PSW = 11;
  localparam int SSSC_B_PSW_LO = 12;
  localparam int SSSC_B_PSW_HI = 13;
  localparam int SSSC_B_PSTOP = 15;
  localparam int SSSC_B_INT_SPEED = 2;
  localparam int SSSC_N_EVT = 4;
  localparam int SSSC_E_ALARM = 0;
  localparam int SSSC_E_OTRAVEL = 1;
  localparam int SSSC_E_ABSTOP = 2;
  localparam int SSSC_E_DEVCLR = 3;
  typedef enum logic [1:0]
  {
    SSSC_PSW_TORQUE = 2'b00,
    SSSC_PSW_SPEED = 2'b01,
    SSSC_PSW_ACCEL = 2'b10,
    SSSC_PSW_DEV = 2'b11
  } sssc_psw_t;
  typedef enum logic [2:0]
  {
    SSSC_ST_IDLE = 3'b000,
    SSSC_ST_RUN = 3'b001,
    SSSC_ST_STOPPING = 3'b010,
    SSSC_ST_STOPPED = 3'b011,
    SSSC_ST_HOLD = 3'b100
  } sssc_state_t;
endpackage
`default_nettype wire

//--- sssc_edge.sv
// rising edge detector for a synchronous input
`default_nettype none
module sssc_edge
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // level in, pulse out
  input wire logic level,
  output logic rise
);
  logic prev_q;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      prev_q <= 1'b0;
    else
      prev_q <= level;
  end
  assign rise = level & ~prev_q;
endmodule
`default_nettype wire

//--- sssc_irq.sv
// sticky event bits with mask and write-one-to-clear
`default_nettype none
module sssc_irq
  import sssc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // events and software access
  input wire logic [SSSC_N_EVT-1:0] evt,
  input wire logic [SSSC_N_EVT-1:0] clr,
  input wire logic [SSSC_N_EVT-1:0] mask_d,
  input wire logic mask_we,
  output logic [SSSC_N_EVT-1:0] stat_q,
  output logic [SSSC_N_EVT-1:0] mask_q,
  output logic irq_q
);
  // set beats clear so a coincident event is kept
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      stat_q <= '0;
      mask_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      stat_q <= (stat_q & ~clr) | evt;
      if (mask_we)
        mask_q <= mask_d;
      irq_q <= |(((stat_q & ~clr) | evt) & mask_q);
    end
  end
endmodule
`default_nettype wire

//--- sssc_top.sv
// sequence setup decode and stop sequencing with apb registers
//
// Added by the designer: the APB register port and the placing of the registers.
`default_nettype none
module sssc_top
  import sssc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // controller inputs
  input wire logic run_input,
  input wire logic forward_travel_prohibit,
  input wire logic reverse_travel_prohibit,
  input wire logic forward_current_limit_input,
  input wire logic reverse_current_limit_input,
  input wire logic shared_input,
  input wire logic command_pulse_in,
  // motor side inputs
  input wire logic rotation_detect,
  input wire logic current_limit_detect,
  input wire logic motor_stopped,
  input wire logic abnormal_stop,
  input wire logic power_recovered,
  input wire logic alarm_event,
  input wire logic psw_torque_over,
  input wire logic psw_speed_over,
  input wire logic psw_accel_over,
  input wire logic psw_dev_over,
  // outputs
  output logic servo_on_q,
  output logic fwd_permit_q,
  output logic rev_permit_q,
  output logic status_out_q,
  output logic servo_alarm_q,
  output logic dyn_brake_q,
  output logic estop_torque_q,
  output logic pos_loop_en_q,
  output logic dev_clear_q,
  output logic p_control_q,
  output logic pulse_accept_q,
  output logic gain_reduce_q,
  output logic irq_q
);
  // power-on value only: stored setup must survive rstn, or writes never apply
  logic [15:0] seq_shadow_q = SSSC_SEQ_RESET;
  logic [15:0] cmd_shadow_q = SSSC_CMD_RESET;
  logic [15:0] seq_act_q;
  logic [15:0] cmd_act_q;
  logic loaded_q;
  sssc_state_t state_q;
  sssc_state_t state_d;
  logic ot_q;
  logic [SSSC_N_EVT-1:0] stat_q;
  logic [SSSC_N_EVT-1:0] mask_q;
  logic pwr_rise;
  logic alm_rise;
  logic abn_rise;

  // apb decode
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire hit_seq = paddr == SSSC_OFF_SEQ_SETUP;
  wire hit_cmd = paddr == SSSC_OFF_CMD_SETUP;
  wire hit_act = paddr == SSSC_OFF_ACTIVE;
  wire hit_sta = paddr == SSSC_OFF_STATUS;
  wire hit_ist = paddr == SSSC_OFF_IRQ_STAT;
  wire hit_msk = paddr == SSSC_OFF_IRQ_MASK;
  wire hit_any = hit_seq | hit_cmd | hit_act | hit_sta | hit_ist | hit_msk;
  wire [31:0] status_word = {16'h0000, 8'h00, 1'b0, state_q, ot_q, servo_alarm_q,
    dyn_brake_q, servo_on_q};
  wire [31:0] rd_mux =
    hit_seq ? {16'h0000, seq_shadow_q} :
    hit_cmd ? {16'h0000, cmd_shadow_q} :
    hit_act ? {cmd_act_q, seq_act_q} :
    hit_sta ? status_word :
    hit_ist ? {28'h000_0000, stat_q} :
    hit_msk ? {28'h000_0000, mask_q} : 32'h0000_0000;

  // shadow words are kept through reset, like stored parameters
  always_ff @(posedge clk_sys)
  begin
    if (wr && hit_seq)
      seq_shadow_q <= pwdata[15:0];
    if (wr && hit_cmd)
      cmd_shadow_q <= pwdata[15:0];
  end

  // active setup copies are taken once after reset release only
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      seq_act_q <= SSSC_SEQ_RESET;
      cmd_act_q <= SSSC_CMD_RESET;
      loaded_q <= 1'b0;
    end
    else
    begin
      loaded_q <= 1'b1;
      if (!loaded_q)
      begin
        seq_act_q <= seq_shadow_q;
        cmd_act_q <= cmd_shadow_q;
      end
    end
  end

  // zero wait state answer, error on unmapped address
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_any;
      prdata <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // decode of the active word
  wire run_forced = seq_act_q[SSSC_B_RUN_FORCE];
  wire int_speed = cmd_act_q[SSSC_B_INT_SPEED];
  wire pstop_en = seq_act_q[SSSC_B_PSTOP];
  wire coast = seq_act_q[SSSC_B_COAST];
  wire ot_torque = seq_act_q[SSSC_B_OT_TORQUE];
  wire ot_hold = seq_act_q[SSSC_B_OT_HOLD];
  wire fwd_ok = seq_act_q[SSSC_B_FWD_IGN] | ~forward_travel_prohibit;
  wire rev_ok = seq_act_q[SSSC_B_REV_IGN] | ~reverse_travel_prohibit;
  wire over_travel = ~fwd_ok | ~rev_ok;
  wire run_req = (run_forced | run_input) & ~servo_alarm_q;
  sssc_psw_t psw_sel;
  assign psw_sel = sssc_psw_t'({seq_act_q[SSSC_B_PSW_HI], seq_act_q[SSSC_B_PSW_LO]});
  wire psw_hit = (psw_sel == SSSC_PSW_TORQUE) ? psw_torque_over :
    (psw_sel == SSSC_PSW_SPEED) ? psw_speed_over :
    (psw_sel == SSSC_PSW_ACCEL) ? psw_accel_over : psw_dev_over;
  // shared input: both limit inputs off blocks pulses in speed mode
  wire pulse_ok = int_speed ? (forward_current_limit_input | reverse_current_limit_input)
    : ~(pstop_en & shared_input);
  // brake open after stop when coasting without torque stop
  wire brake_after = (coast & ~ot_torque) ? 1'b0 : seq_act_q[SSSC_B_BRAKE_HOLD];

  sssc_edge u_pwr
  (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .level(power_recovered),
    .rise(pwr_rise)
  );
  sssc_edge u_alm
  (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .level(alarm_event),
    .rise(alm_rise)
  );
  sssc_edge u_abn
  (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .level(abnormal_stop),
    .rise(abn_rise)
  );

  // stop sequencer
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      SSSC_ST_IDLE:
        if (run_req && !abnormal_stop)
          state_d = SSSC_ST_RUN;
      SSSC_ST_RUN:
        if (abnormal_stop || over_travel || !run_req)
          state_d = SSSC_ST_STOPPING;
      SSSC_ST_STOPPING:
        if (motor_stopped)
          state_d = (ot_q && ot_hold && run_req) ? SSSC_ST_HOLD : SSSC_ST_STOPPED;
      SSSC_ST_STOPPED:
        if (!abnormal_stop && !over_travel)
          state_d = SSSC_ST_IDLE;
      SSSC_ST_HOLD:
        if (!over_travel || !run_req)
          state_d = SSSC_ST_IDLE;
      default:
        state_d = SSSC_ST_IDLE;
    endcase
  end

  wire stopping = state_q == SSSC_ST_STOPPING;
  wire stopped = state_q == SSSC_ST_STOPPED;
  wire brake_d = stopping ? ~coast & ~(ot_q & ot_torque) :
    stopped ? brake_after : 1'b0;
  wire servo_d = (state_q == SSSC_ST_RUN) | (state_q == SSSC_ST_HOLD) |
    (stopping & ot_q & ot_torque);
  wire dev_clr_d = alm_rise & ~servo_on_q & ~seq_act_q[SSSC_B_KEEP_DEV];
  wire alarm_set = alm_rise | (pwr_rise & ~seq_act_q[SSSC_B_AUTO_CLR]);
  wire alarm_clr = pwr_rise & seq_act_q[SSSC_B_AUTO_CLR];

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= SSSC_ST_IDLE;
      ot_q <= 1'b0;
      servo_alarm_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == SSSC_ST_RUN && state_d == SSSC_ST_STOPPING)
        ot_q <= over_travel & ~abnormal_stop;
      else if (state_d == SSSC_ST_IDLE)
        ot_q <= 1'b0;
      if (alarm_set)
        servo_alarm_q <= 1'b1;
      else if (alarm_clr)
        servo_alarm_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      servo_on_q <= 1'b0;
      fwd_permit_q <= 1'b0;
      rev_permit_q <= 1'b0;
      status_out_q <= 1'b0;
      dyn_brake_q <= 1'b0;
      estop_torque_q <= 1'b0;
      pos_loop_en_q <= 1'b0;
      dev_clear_q <= 1'b0;
      p_control_q <= 1'b0;
      pulse_accept_q <= 1'b0;
      gain_reduce_q <= 1'b0;
    end
    else
    begin
      servo_on_q <= servo_d;
      fwd_permit_q <= fwd_ok;
      rev_permit_q <= rev_ok;
      status_out_q <= seq_act_q[SSSC_B_STAT_SEL] ? current_limit_detect : rotation_detect;
      dyn_brake_q <= brake_d;
      estop_torque_q <= stopping & ot_q & ot_torque;
      // no position loop while locked after over-travel
      pos_loop_en_q <= (state_q == SSSC_ST_RUN) & ~int_speed;
      dev_clear_q <= dev_clr_d;
      p_control_q <= ~seq_act_q[SSSC_B_NO_PSW] & psw_hit;
      pulse_accept_q <= pulse_ok & command_pulse_in & servo_d;
      gain_reduce_q <= ~int_speed & ~pstop_en & shared_input;
    end
  end

  sssc_irq u_irq
  (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .evt({dev_clr_d, abn_rise, stopping & ot_q & motor_stopped, alarm_set}),
    .clr((wr && hit_ist) ? pwdata[SSSC_N_EVT-1:0] : {SSSC_N_EVT{1'b0}}),
    .mask_d(pwdata[SSSC_N_EVT-1:0]),
    .mask_we(wr & hit_msk),
    .stat_q(stat_q),
    .mask_q(mask_q),
    .irq_q(irq_q)
  );

  a_status_select: assert property (@(posedge clk_sys) disable iff (!rstn)
    seq_act_q[SSSC_B_STAT_SEL] |=> status_out_q == $past(current_limit_detect))
    else $error("status output source wrong");
  a_forced_run: assert property (@(posedge clk_sys) disable iff (!rstn)
    (run_forced && !servo_alarm_q && state_q == SSSC_ST_IDLE && !abnormal_stop)
    |=> state_q == SSSC_ST_RUN)
    else $error("forced run not entered");
  a_fwd_permit: assert property (@(posedge clk_sys) disable iff (!rstn)
    seq_act_q[SSSC_B_FWD_IGN] |=> fwd_permit_q)
    else $error("forward blocked while ignored");
  a_rev_permit: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!seq_act_q[SSSC_B_REV_IGN] && reverse_travel_prohibit) |=> !rev_permit_q)
    else $error("reverse not blocked");
  a_active_frozen: assert property (@(posedge clk_sys) disable iff (!rstn)
    loaded_q |=> $stable(seq_act_q))
    else $error("active setup changed while running");
  a_coast_brake: assert property (@(posedge clk_sys) disable iff (!rstn)
    (stopped && coast && !ot_torque) |=> !dyn_brake_q)
    else $error("brake held in coast mode");
  a_auto_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
    (alarm_clr && !alm_rise) |=> !servo_alarm_q)
    else $error("alarm not auto-cleared");
  a_speed_pulses: assert property (@(posedge clk_sys) disable iff (!rstn)
    (int_speed && !forward_current_limit_input && !reverse_current_limit_input)
    |=> !pulse_accept_q)
    else $error("pulse accepted with limits off");
  c_run_stop: cover property (@(posedge clk_sys) disable iff (!rstn)
    state_q == SSSC_ST_RUN ##[1:20] state_q == SSSC_ST_STOPPED);
  c_hold: cover property (@(posedge clk_sys) disable iff (!rstn) state_q == SSSC_ST_HOLD);
  c_irq: cover property (@(posedge clk_sys) disable iff (!rstn) irq_q);
endmodule
`default_nettype wire

//--- sssc_ctrl_model.sv
// motion controller model driving the run, limit and pulse lines
`default_nettype none
module sssc_ctrl_model
(
  // clock and requested levels
  input wire logic clk_sys,
  input wire logic [6:0] want,
  // controller lines
  output logic run_input,
  output logic forward_travel_prohibit,
  output logic reverse_travel_prohibit,
  output logic forward_current_limit_input,
  output logic reverse_current_limit_input,
  output logic shared_input,
  output logic command_pulse_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] lines_q = 7'h00;
  // lines move only after an edge, like a real controller's outputs
  always @(posedge clk_sys)
  begin
    lines_q <= want;
  end
  assign {run_input, forward_travel_prohibit, reverse_travel_prohibit,
    forward_current_limit_input, reverse_current_limit_input, shared_input,
    command_pulse_in} = lines_q;
endmodule
`default_nettype wire

//--- sssc_tb_top.sv
// self-checking bench for the sequence setup block
`default_nettype none
module sssc_tb_top
  import sssc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed
  {
    logic [15:0] seq;
    logic [15:0] cmd;
    logic [11:0] inp;
    logic [7:0] exp;
    logic [7:0] care;
  } sssc_row_t;
  // inp: run fp rp fcl | rcl sh rot cld | psw; exp: - servo fwd rev | stat pctl pacc gred
  localparam sssc_row_t rows [9] = '{
    '{16'h0000, 16'h0408, 12'hC61, 8'h1D, 8'h7F},
    '{16'h0000, 16'h0408, 12'h210, 8'h20, 8'h7D},
    '{16'h101D, 16'h0408, 12'h612, 8'h7E, 8'h7F},
    '{16'hA001, 16'h0408, 12'h044, 8'h74, 8'h7F},
    '{16'h3001, 16'h0408, 12'h048, 8'h77, 8'h7F},
    '{16'h3801, 16'h0408, 12'h00F, 8'h72, 8'h7F},
    '{16'h8001, 16'h040C, 12'h040, 8'h70, 8'h7F},
    '{16'h8001, 16'h040C, 12'h140, 8'h72, 8'h7F},
    '{16'h0001, 16'h040C, 12'h000, 8'h70, 8'h7F}};
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [6:0] want = 7'h01;
  logic [3:0] psw = 4'h0;
  logic rot = 1'b0, cld = 1'b0, stopped = 1'b0, abn = 1'b0, pwr = 1'b0, alm = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, irq_a;
  logic run_input, forward_travel_prohibit, reverse_travel_prohibit, shared_input;
  logic forward_current_limit_input, reverse_current_limit_input, command_pulse_in;
  logic servo_on_q, fwd_permit_q, rev_permit_q, status_out_q, servo_alarm_q, dyn_brake_q;
  logic estop_torque_q, pos_loop_en_q, dev_clear_q, p_control_q, pulse_accept_q;
  logic gain_reduce_q, irq_q;
  int num_errors = 0;
  int cmp_count = 0;
  always #10 clk_sys = ~clk_sys;
  sssc_ctrl_model ctrl (.clk_sys, .want, .run_input, .forward_travel_prohibit,
    .reverse_travel_prohibit, .forward_current_limit_input, .reverse_current_limit_input,
    .shared_input, .command_pulse_in);
  sssc_top uut (.clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .run_input, .forward_travel_prohibit, .reverse_travel_prohibit,
    .forward_current_limit_input, .reverse_current_limit_input, .shared_input,
    .command_pulse_in, .rotation_detect(rot), .current_limit_detect(cld),
    .motor_stopped(stopped), .abnormal_stop(abn), .power_recovered(pwr),
    .alarm_event(alm), .psw_torque_over(psw[0]), .psw_speed_over(psw[1]),
    .psw_accel_over(psw[2]), .psw_dev_over(psw[3]), .servo_on_q, .fwd_permit_q,
    .rev_permit_q, .status_out_q, .servo_alarm_q, .dyn_brake_q, .estop_torque_q,
    .pos_loop_en_q, .dev_clear_q, .p_control_q, .pulse_accept_q, .gain_reduce_q, .irq_q);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk({31'h0000_0000, pready}, 32'h0000_0001);
  endtask

  // setup words only load at a power cycle, so every row goes through reset
  task automatic do_reset;
    rstn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
  endtask

  task automatic close_out;
    if (num_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    apb(1'b0, SSSC_OFF_SEQ_SETUP, 32'h0000_0000);
    chk(rd, {16'h0000, SSSC_SEQ_RESET});
    apb(1'b0, SSSC_OFF_CMD_SETUP, 32'h0000_0000);
    chk(rd, {16'h0000, SSSC_CMD_RESET});
    foreach (rows[i])
    begin
      apb(1'b1, SSSC_OFF_SEQ_SETUP, {16'h0000, rows[i].seq});
      apb(1'b1, SSSC_OFF_CMD_SETUP, {16'h0000, rows[i].cmd});
      {want[6:1], rot, cld, psw} <= rows[i].inp;
      do_reset();
      repeat (5) @(posedge clk_sys);
      chk({24'h00_0000, {1'b0, servo_on_q, fwd_permit_q, rev_permit_q, status_out_q,
        p_control_q, pulse_accept_q, gain_reduce_q} & rows[i].care},
        {24'h00_0000, rows[i].exp & rows[i].care});
    end
    pwr <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk({31'h0000_0000, servo_alarm_q}, 32'h0000_0001);
    pwr <= 1'b0;
    apb(1'b1, SSSC_OFF_SEQ_SETUP, {16'h0000, SSSC_SEQ_RESET});
    apb(1'b1, SSSC_OFF_CMD_SETUP, {16'h0000, SSSC_CMD_RESET});
    apb(1'b0, SSSC_OFF_ACTIVE, 32'h0000_0000);
    chk(rd, 32'h040C_0001);
    want <= 7'h41;
    do_reset();
    apb(1'b0, SSSC_OFF_ACTIVE, 32'h0000_0000);
    chk(rd, {SSSC_CMD_RESET, SSSC_SEQ_RESET});
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk({rd[30:0], err}, 32'h0000_0001);
    apb(1'b1, 12'h020, 32'hFFFF_FFFF);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    alm <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk({30'h0000_0000, servo_alarm_q, servo_on_q}, 32'h0000_0002);
    apb(1'b0, SSSC_OFF_IRQ_STAT, 32'h0000_0000);
    chk(rd & 32'h0000_0001, 32'h0000_0001);
    // mask polarity is the designer's: only demand that it changes the line
    apb(1'b1, SSSC_OFF_IRQ_MASK, 32'h0000_0000);
    repeat (2) @(posedge clk_sys);
    irq_a = irq_q;
    apb(1'b1, SSSC_OFF_IRQ_MASK, 32'h0000_000F);
    repeat (2) @(posedge clk_sys);
    chk({31'h0000_0000, irq_a ^ irq_q}, 32'h0000_0001);
    apb(1'b1, SSSC_OFF_IRQ_STAT, 32'h0000_000F);
    apb(1'b0, SSSC_OFF_IRQ_STAT, 32'h0000_0000);
    chk(rd & 32'h0000_0001, 32'h0000_0000);
    pwr <= 1'b1;
    stopped <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk({30'h0000_0000, servo_alarm_q, servo_on_q}, 32'h0000_0001);
    pwr <= 1'b0;
    alm <= 1'b0;
    abn <= 1'b1;
    repeat (5) @(posedge clk_sys);
    stopped <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk({31'h0000_0000, dyn_brake_q}, 32'h0000_0000);
    apb(1'b0, SSSC_OFF_IRQ_STAT, 32'h0000_0000);
    chk(rd & 32'h0000_0004, 32'h0000_0004);
    close_out();
  end

  initial
  begin
    repeat (5000) @(posedge clk_sys);
    chk(32'h0000_0000, 32'h0000_0001);
    close_out();
  end
endmodule
`default_nettype wire
